// ### verilog/smd_cfg.svh
/*
 * Constants of the signed multiply and divide unit: operand, counter and
 * correction widths, instruction length and the cycle count of every case.
 * Assumes inclusion by bare name from the design modules smd_arith and smd_unit.
 */
`ifndef SMD_CFG_SVH
`define SMD_CFG_SVH

// Operand, counter and correction widths
`define SMD_ACC_W        32
`define SMD_OPND_W       16
`define SMD_CNT_W        8
`define SMD_ADDR_CORR_W  5
`define SMD_BUS_CORR_W   4

// Instruction length in bytes of every form handled here
`define SMD_INSTR_LEN    3'h2

// Signed byte divide, accumulator only
`define SMD_DB_ACC_ZERO  8'h03
`define SMD_DB_ACC_OVE   8'h08
`define SMD_DB_ACC_OVL   8'h12
`define SMD_DB_ACC_NORM  8'h12
// Signed byte divide, register operand
`define SMD_DB_REG_ZERO  8'h03
`define SMD_DB_REG_OVE   8'h0a
`define SMD_DB_REG_OVL   8'h15
`define SMD_DB_REG_NORM  8'h16
// Signed byte divide, memory operand (before corrections)
`define SMD_DB_MEM_ZERO  8'h04
`define SMD_DB_MEM_OVE   8'h0b
`define SMD_DB_MEM_OVL   8'h16
`define SMD_DB_MEM_NORM  8'h17
// Signed word divide, register operand, positive / negative dividend
`define SMD_DW_REG_ZERO  8'h04
`define SMD_DW_REGP_OVE  8'h0a
`define SMD_DW_REGP_OVL  8'h1d
`define SMD_DW_REGP_NORM 8'h1e
`define SMD_DW_REGN_OVE  8'h0b
`define SMD_DW_REGN_OVL  8'h1e
`define SMD_DW_REGN_NORM 8'h1f
// Signed word divide, memory operand, positive / negative dividend
`define SMD_DW_MEM_ZERO  8'h04
`define SMD_DW_MEMP_OVE  8'h0b
`define SMD_DW_MEMP_OVL  8'h1e
`define SMD_DW_MEMP_NORM 8'h1f
`define SMD_DW_MEMN_OVE  8'h0c
`define SMD_DW_MEMN_OVL  8'h1f
`define SMD_DW_MEMN_NORM 8'h20
// Signed byte multiply: zero / positive / negative
`define SMD_MB_ZERO      8'h03
`define SMD_MB_POS       8'h0c
`define SMD_MB_NEG       8'h0d
`define SMD_MB_MEM_ZERO  8'h04
`define SMD_MB_MEM_POS   8'h0d
`define SMD_MB_MEM_NEG   8'h0e
// Signed word multiply: accumulator, register, memory
`define SMD_MW_ACC_ZERO  8'h03
`define SMD_MW_ACC_POS   8'h0c
`define SMD_MW_ACC_NEG   8'h0d
`define SMD_MW_REG_ZERO  8'h03
`define SMD_MW_REG_POS   8'h10
`define SMD_MW_REG_NEG   8'h13
`define SMD_MW_MEM_ZERO  8'h04
`define SMD_MW_MEM_POS   8'h11
`define SMD_MW_MEM_NEG   8'h14

`endif

// ### verilog/smd_pkg.sv
/*
 * Types of the signed multiply and divide unit: operation, operand source
 * and sequencer state.
 * Assumes smd_cfg.svh is on the include path.
 */
package smd_pkg;
    typedef enum logic [1:0]
    {
        SMD_OP_QUOT_BYTE              = 2'b00,
        SMD_OP_SIGNED_QUOTIENT_WORD_OP = 2'b01,
        SMD_OP_SIGNED_PRODUCT_BYTE_OP  = 2'b10,
        SMD_OP_SIGNED_PRODUCT_WORD_OP  = 2'b11
    } smd_op_t;

    typedef enum logic [1:0]
    {
        SMD_SRC_ACC = 2'b00,
        SMD_SRC_REG = 2'b01,
        SMD_SRC_MEM = 2'b10
    } smd_src_t;

    typedef enum logic
    {
        SMD_ST_IDLE = 1'b0,
        SMD_ST_RUN  = 1'b1
    } smd_state_t;
endpackage : smd_pkg

// ### verilog/smd_arith.sv
/*
 * Combinational two's-complement arithmetic of the unit: quotient,
 * remainder, product, zero, overflow and sign classification.
 * Assumes operands are stable while the caller samples the results.
 */
`timescale 1ns/1ns
`include "smd_cfg.svh"

module smd_arith
    import smd_pkg::*;
(
    input  smd_pkg::smd_op_t            op,        // Operation
    input  smd_pkg::smd_src_t           src,       // Operand source
    input  wire logic [`SMD_ACC_W-1:0]  acc,       // Accumulator, upper:lower
    input  wire logic [`SMD_OPND_W-1:0] opnd,      // Register or memory operand
    output logic      [`SMD_ACC_W-1:0]  res_acc,   // New accumulator
    output logic      [`SMD_OPND_W-1:0] res_opnd,  // New operand
    output logic                        opnd_upd,  // Operand gets a result
    output logic                        is_zero,   // Zero divisor or multiplier
    output logic                        ovf,       // Quotient out of range
    output logic                        ovf_early, // Overflow seen before divide
    output logic                        neg        // Negative result or dividend
);
    logic signed [33:0] dvd;
    logic signed [33:0] dvs;
    logic signed [33:0] quo;
    logic signed [33:0] rem;
    logic signed [33:0] prd;
    logic signed [33:0] mag_dvd;
    logic signed [33:0] mag_lim;
    logic               is_div;
    logic               is_word;

    always_comb
    begin
        is_div  = (op == SMD_OP_QUOT_BYTE) || (op == SMD_OP_SIGNED_QUOTIENT_WORD_OP);
        is_word = (op == SMD_OP_SIGNED_QUOTIENT_WORD_OP) || (op == SMD_OP_SIGNED_PRODUCT_WORD_OP);
        dvd = '0;
        dvs = '0;
        case (op)
            SMD_OP_QUOT_BYTE:
            begin
                // Upper word over lower byte, or lower word over operand byte
                dvd = (src == SMD_SRC_ACC) ? 34'(signed'(acc[31:16])) : 34'(signed'(acc[15:0]));
                dvs = (src == SMD_SRC_ACC) ? 34'(signed'(acc[7:0])) : 34'(signed'(opnd[7:0]));
            end
            SMD_OP_SIGNED_QUOTIENT_WORD_OP:
            begin
                dvd = 34'(signed'(acc));
                dvs = 34'(signed'(opnd));
            end
            SMD_OP_SIGNED_PRODUCT_BYTE_OP:
            begin
                dvd = (src == SMD_SRC_ACC) ? 34'(signed'(acc[23:16])) : 34'(signed'(acc[7:0]));
                dvs = (src == SMD_SRC_ACC) ? 34'(signed'(acc[7:0])) : 34'(signed'(opnd[7:0]));
            end
            default:
            begin
                dvd = (src == SMD_SRC_ACC) ? 34'(signed'(acc[31:16])) : 34'(signed'(acc[15:0]));
                dvs = (src == SMD_SRC_ACC) ? 34'(signed'(acc[15:0])) : 34'(signed'(opnd));
            end
        endcase
        // Truncating divide: remainder takes the dividend's sign
        quo = (dvs == 34'sh0) ? 34'sh0 : dvd / dvs;
        rem = (dvs == 34'sh0) ? 34'sh0 : dvd % dvs;
        prd = dvd * dvs;
        mag_dvd = (dvd < 0) ? -dvd : dvd;
        mag_lim = ((dvs < 0) ? -dvs : dvs) <<< (is_word ? 16 : 8);
        if (is_div)
        begin
            is_zero   = (dvs == 34'sh0);
            ovf       = !is_zero && (is_word ? (quo > 34'sh7fff || quo < -34'sh8000)
                                             : (quo > 34'sh7f || quo < -34'sh80));
            // Quotient magnitude provably too big before any step
            ovf_early = ovf && (mag_dvd >= mag_lim);
            neg       = dvd < 0;
        end
        else
        begin
            // Multiplier zero test looks at the upper or operand factor
            is_zero   = (src == SMD_SRC_ACC) ? (dvd == 34'sh0) : (dvs == 34'sh0);
            ovf       = 1'b0;
            ovf_early = 1'b0;
            neg       = prd < 0;
        end
        res_acc  = acc;
        res_opnd = opnd;
        opnd_upd = 1'b0;
        case (op)
            SMD_OP_QUOT_BYTE:
            begin
                if (src == SMD_SRC_ACC)
                    res_acc = {acc[31:24], rem[7:0], acc[15:8], quo[7:0]};
                else
                begin
                    res_acc  = {acc[31:8], quo[7:0]};
                    res_opnd = {opnd[15:8], rem[7:0]};
                    opnd_upd = 1'b1;
                end
            end
            SMD_OP_SIGNED_QUOTIENT_WORD_OP:
            begin
                res_acc  = {acc[31:16], quo[15:0]};
                res_opnd = rem[15:0];
                opnd_upd = 1'b1;
            end
            SMD_OP_SIGNED_PRODUCT_BYTE_OP:
                res_acc = {acc[31:16], prd[15:0]};
            default:
                res_acc = prd[31:0];
        endcase
    end
endmodule : smd_arith

// ### verilog/smd_unit.sv
/*
 * Signed multiply and divide execution unit. Takes one operation per start,
 * holds busy for the documented cycle count and presents registered results
 * with a one-cycle done strobe.
 * Assumes the CPU keeps operands stable in the start cycle only and supplies
 * the addressing and bus correction cycle counts for memory operands.
 */
`timescale 1ns/1ns
`include "smd_cfg.svh"

module smd_unit
    import smd_pkg::*;
(
    input  wire logic                             sys_clk,     // CPU clock
    input  wire logic                             arst_n,      // Async reset, low
    input  wire logic                             start,       // Begin operation
    input  smd_pkg::smd_op_t                      op,          // Operation
    input  smd_pkg::smd_src_t                     src,         // Operand source
    input  wire logic [`SMD_ACC_W-1:0]            acc_in,      // Accumulator
    input  wire logic [`SMD_OPND_W-1:0]           opnd_in,     // Operand
    input  wire logic [`SMD_ADDR_CORR_W-1:0]      addr_corr,   // Addressing cycles
    input  wire logic [`SMD_BUS_CORR_W-1:0]       bus_corr,    // Bus correction cycles
    output logic                                  busy,        // Operation running
    output logic                                  done,        // Last cycle strobe
    output logic      [`SMD_ACC_W-1:0]            acc_out,     // New accumulator
    output logic      [`SMD_OPND_W-1:0]           opnd_out,    // New operand
    output logic                                  acc_wr,      // Write accumulator
    output logic                                  opnd_wr,     // Write operand
    output logic                                  flag_v,      // Overflow flag
    output logic                                  flag_c,      // Carry flag
    output logic                                  flags_wr,    // Write V and C
    output logic      [2:0]                       instr_len    // Encoding length
);
    logic [`SMD_ACC_W-1:0]  a_res;
    logic [`SMD_OPND_W-1:0] a_opnd;
    logic                   a_opnd_upd;
    logic                   a_zero;
    logic                   a_ovf;
    logic                   a_early;
    logic                   a_neg;
    logic                   take;
    logic                   is_div;
    smd_state_t             state_r;
    smd_state_t             state_nxt;
    logic [`SMD_CNT_W-1:0]  cnt_r;
    logic [`SMD_CNT_W-1:0]  len_r;
    logic [`SMD_CNT_W-1:0]  age_r;
    logic                   div_r;
    logic                   fail_r;
    logic                   opnd_upd_r;
    logic                   mul_run_r;

    // Cycle count of one case, including memory corrections
    function automatic logic [`SMD_CNT_W-1:0] cycles_f
    (
        input smd_op_t                     f_op,
        input smd_src_t                    f_src,
        input logic                        f_zero,
        input logic                        f_ovf,
        input logic                        f_early,
        input logic                        f_neg,
        input logic [`SMD_ADDR_CORR_W-1:0] f_addr,
        input logic [`SMD_BUS_CORR_W-1:0]  f_bus
    );
        logic [`SMD_CNT_W-1:0] base;
        logic [`SMD_CNT_W-1:0] corr;
        logic                  f_div;
        base  = '0;
        f_div = (f_op == SMD_OP_QUOT_BYTE) || (f_op == SMD_OP_SIGNED_QUOTIENT_WORD_OP);
        case (f_op)
            SMD_OP_QUOT_BYTE:
            begin
                case (f_src)
                    SMD_SRC_ACC: base = f_zero ? `SMD_DB_ACC_ZERO :
                                        f_ovf ? (f_early ? `SMD_DB_ACC_OVE : `SMD_DB_ACC_OVL)
                                              : `SMD_DB_ACC_NORM;
                    SMD_SRC_MEM: base = f_zero ? `SMD_DB_MEM_ZERO :
                                        f_ovf ? (f_early ? `SMD_DB_MEM_OVE : `SMD_DB_MEM_OVL)
                                              : `SMD_DB_MEM_NORM;
                    default:     base = f_zero ? `SMD_DB_REG_ZERO :
                                        f_ovf ? (f_early ? `SMD_DB_REG_OVE : `SMD_DB_REG_OVL)
                                              : `SMD_DB_REG_NORM;
                endcase
            end
            SMD_OP_SIGNED_QUOTIENT_WORD_OP:
            begin
                if (f_src == SMD_SRC_MEM)
                begin
                    if (f_zero)
                        base = `SMD_DW_MEM_ZERO;
                    else if (f_neg)
                        base = f_ovf ? (f_early ? `SMD_DW_MEMN_OVE : `SMD_DW_MEMN_OVL) : `SMD_DW_MEMN_NORM;
                    else
                        base = f_ovf ? (f_early ? `SMD_DW_MEMP_OVE : `SMD_DW_MEMP_OVL) : `SMD_DW_MEMP_NORM;
                end
                else
                begin
                    if (f_zero)
                        base = `SMD_DW_REG_ZERO;
                    else if (f_neg)
                        base = f_ovf ? (f_early ? `SMD_DW_REGN_OVE : `SMD_DW_REGN_OVL) : `SMD_DW_REGN_NORM;
                    else
                        base = f_ovf ? (f_early ? `SMD_DW_REGP_OVE : `SMD_DW_REGP_OVL) : `SMD_DW_REGP_NORM;
                end
            end
            SMD_OP_SIGNED_PRODUCT_BYTE_OP:
            begin
                if (f_src == SMD_SRC_MEM)
                    base = f_zero ? `SMD_MB_MEM_ZERO : (f_neg ? `SMD_MB_MEM_NEG : `SMD_MB_MEM_POS);
                else
                    base = f_zero ? `SMD_MB_ZERO : (f_neg ? `SMD_MB_NEG : `SMD_MB_POS);
            end
            default:
            begin
                case (f_src)
                    SMD_SRC_ACC: base = f_zero ? `SMD_MW_ACC_ZERO :
                                        (f_neg ? `SMD_MW_ACC_NEG : `SMD_MW_ACC_POS);
                    SMD_SRC_MEM: base = f_zero ? `SMD_MW_MEM_ZERO :
                                        (f_neg ? `SMD_MW_MEM_NEG : `SMD_MW_MEM_POS);
                    default:     base = f_zero ? `SMD_MW_REG_ZERO :
                                        (f_neg ? `SMD_MW_REG_NEG : `SMD_MW_REG_POS);
                endcase
            end
        endcase
        corr = '0;
        if (f_src == SMD_SRC_MEM)
        begin
            corr = `SMD_CNT_W'(f_addr) + `SMD_CNT_W'(f_bus);
            // Normal divide reads and writes back the operand
            if (f_div && !f_zero && !f_ovf)
                corr = corr + `SMD_CNT_W'(f_bus);
        end
        return base + corr;
    endfunction : cycles_f

    smd_arith u_arith
    (
        .op        (op),
        .src       (src),
        .acc       (acc_in),
        .opnd      (opnd_in),
        .res_acc   (a_res),
        .res_opnd  (a_opnd),
        .opnd_upd  (a_opnd_upd),
        .is_zero   (a_zero),
        .ovf       (a_ovf),
        .ovf_early (a_early),
        .neg       (a_neg)
    );

    assign take   = start && (state_r == SMD_ST_IDLE);
    assign is_div = (op == SMD_OP_QUOT_BYTE) || (op == SMD_OP_SIGNED_QUOTIENT_WORD_OP);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            SMD_ST_IDLE: if (take) state_nxt = SMD_ST_RUN;
            SMD_ST_RUN:  if (cnt_r == `SMD_CNT_W'(1)) state_nxt = SMD_ST_IDLE;
            default:     state_nxt = SMD_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            state_r <= SMD_ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // Remaining cycles, loaded with the case's full count
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_r <= '0;
            len_r <= '0;
            age_r <= '0;
        end
        else if (take)
        begin
            cnt_r <= cycles_f(op, src, a_zero, a_ovf, a_early, a_neg, addr_corr, bus_corr);
            len_r <= cycles_f(op, src, a_zero, a_ovf, a_early, a_neg, addr_corr, bus_corr);
            age_r <= `SMD_CNT_W'(1);
        end
        else if (state_r == SMD_ST_RUN)
        begin
            cnt_r <= cnt_r - `SMD_CNT_W'(1);
            age_r <= age_r + `SMD_CNT_W'(1);
        end
    end

    // Results latched at start, written back on done
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            acc_out    <= '0;
            opnd_out   <= '0;
            div_r      <= 1'b0;
            fail_r     <= 1'b0;
            opnd_upd_r <= 1'b0;
            flag_v     <= 1'b0;
            flag_c     <= 1'b0;
        end
        else if (take)
        begin
            acc_out    <= a_res;
            opnd_out   <= a_opnd;
            div_r      <= is_div;
            fail_r     <= is_div && (a_zero || a_ovf);
            opnd_upd_r <= a_opnd_upd;
            flag_v     <= is_div && (a_zero || a_ovf);
            flag_c     <= is_div && a_zero;
        end
    end

    assign busy      = (state_r == SMD_ST_RUN);
    assign done      = busy && (cnt_r == `SMD_CNT_W'(1));
    assign acc_wr    = done && !fail_r;
    assign opnd_wr   = done && !fail_r && opnd_upd_r;
    assign flags_wr  = done && div_r;
    assign instr_len = `SMD_INSTR_LEN;

    AST_DONE_AT_LEN: assert property (@(posedge sys_clk) disable iff (!arst_n)
        done |-> (age_r == len_r))
        else $error("done not at loaded cycle count");

    AST_DB_ACC_ZERO: assert property (@(posedge sys_clk) disable iff (!arst_n)
        take && op == SMD_OP_QUOT_BYTE && src == SMD_SRC_ACC && acc_in[7:0] == 8'h00
        |-> ##3 done)
        else $error("accumulator byte divide by zero not 3 cycles");

    AST_DB_ACC_EARLY: assert property (@(posedge sys_clk) disable iff (!arst_n)
        take && op == SMD_OP_QUOT_BYTE && src == SMD_SRC_ACC && a_ovf && a_early
        |-> ##8 done)
        else $error("early overflow byte divide not 8 cycles");

    AST_DB_REG_NORM: assert property (@(posedge sys_clk) disable iff (!arst_n)
        take && op == SMD_OP_QUOT_BYTE && src == SMD_SRC_REG && !a_zero && !a_ovf
        |=> (cnt_r == 8'h16) ##21 done)
        else $error("register byte divide not 22 cycles");

    AST_DW_REG_NEG: assert property (@(posedge sys_clk) disable iff (!arst_n)
        take && op == SMD_OP_SIGNED_QUOTIENT_WORD_OP && src == SMD_SRC_REG
        && !a_zero && !a_ovf && acc_in[31] |-> ##31 done)
        else $error("negative word divide not 31 cycles");

    AST_MEM_DB_CORR: assert property (@(posedge sys_clk) disable iff (!arst_n)
        take && op == SMD_OP_QUOT_BYTE && src == SMD_SRC_MEM && !a_zero && !a_ovf
        |=> len_r == 8'h17 + 8'($past(addr_corr)) + 8'($past(bus_corr)) * 8'h02)
        else $error("memory byte divide correction wrong");

    // Assertion helper: a byte multiply is in flight
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
            mul_run_r <= 1'b0;
        else if (take)
            mul_run_r <= (op == SMD_OP_SIGNED_PRODUCT_BYTE_OP);
        else if (done)
            mul_run_r <= 1'b0;
    end

    AST_MUL_NO_FLAGS: assert property (@(posedge sys_clk) disable iff (!arst_n)
        mul_run_r |-> !flags_wr)
        else $error("multiply touched flags");

    AST_MB_NEG: assert property (@(posedge sys_clk) disable iff (!arst_n)
        take && op == SMD_OP_SIGNED_PRODUCT_BYTE_OP && src == SMD_SRC_ACC && !a_zero && a_neg
        |-> ##13 (done && acc_wr && acc_out[15]))
        else $error("negative byte multiply not 13 cycles");

    AST_MB_MEM_ZERO: assert property (@(posedge sys_clk) disable iff (!arst_n)
        take && op == SMD_OP_SIGNED_PRODUCT_BYTE_OP && src == SMD_SRC_MEM && a_zero
        |=> cnt_r == 8'h04 + 8'($past(addr_corr)) + 8'($past(bus_corr)))
        else $error("memory byte multiply by zero count wrong");

    AST_MW_REG_POS: assert property (@(posedge sys_clk) disable iff (!arst_n)
        take && op == SMD_OP_SIGNED_PRODUCT_WORD_OP && src == SMD_SRC_REG && !a_zero && !a_neg
        |-> ##16 done)
        else $error("positive register word multiply not 16 cycles");

    AST_DIV_FLAGS: assert property (@(posedge sys_clk) disable iff (!arst_n)
        flags_wr && flag_v |-> !acc_wr && !opnd_wr)
        else $error("failed divide wrote results");

    AST_REM_SIGN: assert property (@(posedge sys_clk) disable iff (!arst_n)
        take && op == SMD_OP_SIGNED_QUOTIENT_WORD_OP && src == SMD_SRC_REG && !a_zero && !a_ovf
        && acc_in[31] && a_opnd != 16'h0000 |=> opnd_out[15])
        else $error("remainder sign differs from dividend");
endmodule : smd_unit

// ### verification/smd_unit_tb.sv
/*
 * Self-checking bench of the signed multiply and divide unit: an integer model
 * predicts cycle count, results, flags and strobes of every operation.
 * Assumes smd_pkg is compiled first and smd_cfg.svh is on the include path.
 */
`timescale 1ns/1ns
`define CHK(nm, ex, sn) begin checks++; if ((ex) !== (sn)) begin failures++; \
    $display("wrong value %s expected %h seen %h", nm, ex, sn); end end

module smd_unit_tb;
    import smd_pkg::*;
    logic        sys_clk = 0, arst_n = 0, start = 0;
    smd_op_t     op = SMD_OP_QUOT_BYTE;
    smd_src_t    src = SMD_SRC_ACC;
    logic [31:0] acc_in = 0, acc_out;
    logic [15:0] opnd_in = 0, opnd_out;
    logic [4:0]  addr_corr = 0;
    logic [3:0]  bus_corr = 0;
    logic        busy, done, acc_wr, opnd_wr, flag_v, flag_c, flags_wr;
    logic [2:0]  instr_len;
    int          failures = 0, checks = 0, cyc = 0, k;
    integer      seed = 20;

    smd_unit i_smd_unit (.sys_clk(sys_clk), .arst_n(arst_n), .start(start), .op(op), .src(src),
        .acc_in(acc_in), .opnd_in(opnd_in), .addr_corr(addr_corr), .bus_corr(bus_corr), .busy(busy),
        .done(done), .acc_out(acc_out), .opnd_out(opnd_out), .acc_wr(acc_wr), .opnd_wr(opnd_wr),
        .flag_v(flag_v), .flag_c(flag_c), .flags_wr(flags_wr), .instr_len(instr_len));

    always #2 sys_clk = ~sys_clk;

    task automatic stop_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            failures++;
            stop_test;
        end
    end

    task automatic go(input smd_op_t o, input smd_src_t s, input logic [31:0] a, input logic [15:0] d,
                      input logic [4:0] ac, input logic [3:0] bc);
        longint      x, y, q, r, p;
        int          n, e;
        logic        z, ov, ng, dv, wd, m, ea, ew, eow;
        logic [31:0] eacc;
        logic [15:0] eo;
        wd = o[0];
        dv = !o[1];
        m = s == SMD_SRC_MEM;
        ov = 0;
        if (dv)
        begin
            x = wd ? $signed(a) : (s == SMD_SRC_ACC ? $signed(a[31:16]) : $signed(a[15:0]));
            y = wd ? $signed(d) : (s == SMD_SRC_ACC ? $signed(a[7:0]) : $signed(d[7:0]));
            z = y == 0;
            q = z ? 0 : x / y;
            r = z ? 0 : x % y;
            ov = !z && (wd ? (q > 32767 || q < -32768) : (q > 127 || q < -128));
            ea = (x < 0 ? -x : x) >= ((y < 0 ? -y : y) << (wd ? 16 : 8));
            if (!wd)
                e = s == SMD_SRC_ACC ? (z ? 3 : ov ? (ea ? 8 : 18) : 18) : s == SMD_SRC_REG ?
                    (z ? 3 : ov ? (ea ? 10 : 21) : 22) : (z ? 4 : ov ? (ea ? 11 : 22) : 23);
            else
                e = z ? 4 : (ov ? (ea ? 10 : 29) : 30) + a[31] + m;
            e += m ? ac + bc + ((z || ov) ? 0 : bc) : 0;
            eacc = wd ? {a[31:16], q[15:0]} : s == SMD_SRC_ACC ? {a[31:24], r[7:0], a[15:8], q[7:0]} :
                {a[31:8], q[7:0]};
            eo = wd ? r[15:0] : {d[15:8], r[7:0]};
            ew = !(z || ov);
            eow = ew && (wd || s != SMD_SRC_ACC);
        end
        else
        begin
            x = wd ? (s == SMD_SRC_ACC ? $signed(a[31:16]) : $signed(a[15:0])) :
                (s == SMD_SRC_ACC ? $signed(a[23:16]) : $signed(a[7:0]));
            y = wd ? (s == SMD_SRC_ACC ? $signed(a[15:0]) : $signed(d)) :
                (s == SMD_SRC_ACC ? $signed(a[7:0]) : $signed(d[7:0]));
            z = s == SMD_SRC_ACC ? x == 0 : y == 0;
            p = x * y;
            ng = p < 0;
            e = z ? 3 + m : wd ? (s == SMD_SRC_ACC ? 12 + ng : 16 + 3 * ng + m) : 12 + ng + m;
            e += m ? ac + bc : 0;
            eacc = wd ? p[31:0] : {a[31:16], p[15:0]};
            ew = 1;
            eow = 0;
        end
        @(negedge sys_clk);
        {start, acc_in, opnd_in, addr_corr, bus_corr} = {1'b1, a, d, ac, bc};
        op = o;
        src = s;
        @(posedge sys_clk);
        n = 0;
        // Junk on start and accumulator while running must be ignored
        do begin
            @(negedge sys_clk);
            n++;
            if (done !== 1'b1)
            begin
                start = 1'($random(seed));
                acc_in = $random(seed);
            end
        end while (done !== 1'b1 && n < 200);
        start = 0;
        `CHK("cycles", e, n)
        `CHK("acc_wr", ew, acc_wr)
        `CHK("opnd_wr", eow, opnd_wr)
        `CHK("flags_wr", dv, flags_wr)
        if (ew) `CHK("acc_out", eacc, acc_out)
        if (eow) `CHK("opnd_out", eo, opnd_out)
        if (dv) `CHK("flags", {z || ov, z}, {flag_v, flag_c})
        `CHK("instr_len", 3'h2, instr_len)
        $display("test op %0d src %0d took %0d cycles", o, s, n);
    endtask : go

    initial
    begin
        logic [31:0] a;
        logic [15:0] d;
        repeat (3) @(negedge sys_clk);
        arst_n = 1;
        go(SMD_OP_QUOT_BYTE, SMD_SRC_REG, 32'h00000064, 16'h0007, 5'h00, 4'h0);
        go(SMD_OP_QUOT_BYTE, SMD_SRC_ACC, 32'h00c80001, 16'h0000, 5'h00, 4'h0);
        go(SMD_OP_QUOT_BYTE, SMD_SRC_ACC, 32'h80000001, 16'h0000, 5'h00, 4'h0);
        go(SMD_OP_SIGNED_QUOTIENT_WORD_OP, SMD_SRC_MEM, 32'h00009c40, 16'h0001, 5'h1f, 4'hf);
        for (k = 0; k < 300; k++)
        begin
            a = $random(seed);
            d = 16'($random(seed));
            case ($random(seed) & 3)
                0: {a, d} = {a & 32'h0000ff00, 16'h0000};
                1: a = $signed(a) >>> 20;
                default: ;
            endcase
            go(smd_op_t'($random(seed)), smd_src_t'({$random(seed)} % 3), a, d, 5'($random(seed)), 4'($random(seed)));
        end
        // Reset in mid-operation
        @(negedge sys_clk);
        {start, acc_in, opnd_in} = {1'b1, 32'h1234, 16'h8001};
        op = SMD_OP_SIGNED_PRODUCT_WORD_OP;
        src = SMD_SRC_REG;
        repeat (2) @(negedge sys_clk);
        {start, arst_n} = 2'b00;
        @(negedge sys_clk);
        `CHK("reset state", 55'h0, {busy, done, acc_wr, opnd_wr, flags_wr, flag_v, flag_c, acc_out, opnd_out})
        arst_n = 1;
        go(SMD_OP_SIGNED_PRODUCT_BYTE_OP, SMD_SRC_ACC, 32'h00fd0005, 16'h0000, 5'h00, 4'h0);
        stop_test;
    end
endmodule : smd_unit_tb
